// file: verilog/cpu_regs_pkg.sv
package cpu_regs_pkg;
    localparam int WORD_W   = 32;
    localparam int NUM_REGS = 8;
    localparam int IP_W     = 24;
    localparam int MACC_W   = 64;
    localparam int CTRL_W   = 8;

    // extend_control layout
    localparam int EXT_TRACE_BIT = 7;
    localparam int EXT_LVL_HI    = 2;
    localparam int EXT_LVL_LO    = 0;
    localparam logic [7:0] EXT_WR_MASK = 8'h87;
    localparam logic [7:0] EXT_RESET   = 8'h07;

    // condition_flags layout
    localparam int CF_I  = 7;
    localparam int CF_UI = 6;
    localparam int CF_H  = 5;
    localparam int CF_U  = 4;
    localparam int CF_N  = 3;
    localparam int CF_Z  = 2;
    localparam int CF_V  = 1;
    localparam int CF_C  = 0;
    localparam logic [7:0] CF_RESET = 8'h80;

    localparam logic [23:0] IP_RESET   = 24'h000000;
    localparam logic [63:0] MACC_RESET = 64'h0;

    // Interrupt refusal after extend_control change, in states
    localparam int          EXT_BLOCK_STATES = 3;
    // The request edge is the first refused state
    localparam logic [1:0]  EXT_BLOCK_LOAD   = 2'(EXT_BLOCK_STATES - 1);

    // Half-carry positions per size
    localparam int HC_BYTE = 3;
    localparam int HC_WORD = 11;
    localparam int HC_LONG = 27;

    // Normal-mode address width
    localparam int NORM_ADDR_W = 16;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} op_size_t;
    // View of a general register selected for an access
    typedef enum logic [1:0] {V_LONG, V_UPPER, V_LOWER, V_BYTE} reg_view_t;
    typedef enum logic [2:0] {
        CO_NONE, CO_LOAD, CO_AND, CO_OR, CO_XOR
    } ctrl_op_t;
    typedef enum logic [2:0] {
        AL_NONE, AL_ADD, AL_SUB, AL_LOGIC, AL_SHIFT, AL_BIT, AL_DAA, AL_DAS
    } alu_kind_t;

    typedef struct packed {
        logic      en;
        logic [2:0] idx;
        reg_view_t view;
        logic      hi_byte;
        logic [31:0] data;
    } gpr_wr_t;

    typedef struct packed {
        logic [2:0] idx;
        reg_view_t  view;
        logic       hi_byte;
    } gpr_rd_t;

    typedef struct packed {
        ctrl_op_t   op;
        logic       to_ext;
        logic [7:0] data;
    } ctrl_req_t;

    typedef struct packed {
        alu_kind_t kind;
        op_size_t  size;
        logic [31:0] a;
        logic [31:0] b;
        logic        cin;
        logic [31:0] result;
        logic        shift_out;
        logic        bit_val;
        logic [2:0]  bit_num;
    } alu_flags_t;
endpackage

// file: verilog/gpr_bank.sv
`timescale 1ns/1ps
module gpr_bank #(
    parameter int N = 8
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_arst_n,
    input  cpu_regs_pkg::gpr_wr_t     i_wr,
    input  cpu_regs_pkg::gpr_rd_t     i_rd,
    output logic [31:0]               o_rdata
);
    typedef struct packed {
        logic [N-1:0][31:0] regs;
        logic [31:0]        rdata;
    } bank_t;
    bank_t s_r, s_nxt;
    logic [31:0] cur;

    always_comb begin
        s_nxt = s_r;
        cur   = s_r.regs[i_rd.idx];
        case (i_rd.view)
            cpu_regs_pkg::V_LONG:  s_nxt.rdata = cur;
            cpu_regs_pkg::V_UPPER: s_nxt.rdata = {16'h0, cur[31:16]};
            cpu_regs_pkg::V_LOWER: s_nxt.rdata = {16'h0, cur[15:0]};
            default:               s_nxt.rdata = {24'h0, i_rd.hi_byte ? cur[15:8] : cur[7:0]};
        endcase
        if (i_wr.en) begin
            case (i_wr.view)                                                   // [RL2]
                cpu_regs_pkg::V_LONG:  s_nxt.regs[i_wr.idx] = i_wr.data;       // [RL1]
                cpu_regs_pkg::V_UPPER: s_nxt.regs[i_wr.idx][31:16] = i_wr.data[15:0]; // [RL3] [RL24]
                cpu_regs_pkg::V_LOWER: s_nxt.regs[i_wr.idx][15:0] = i_wr.data[15:0];  // [RL3] [RL24]
                default: begin
                    if (i_wr.hi_byte) begin
                        s_nxt.regs[i_wr.idx][15:8] = i_wr.data[7:0];           // [RL4] [RL24]
                    end else begin
                        s_nxt.regs[i_wr.idx][7:0] = i_wr.data[7:0];            // [RL4] [RL24]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.rdata;
endmodule // gpr_bank

// file: verilog/flag_calc.sv
`timescale 1ns/1ps
module flag_calc (
    input  cpu_regs_pkg::alu_flags_t i_op,
    input  wire logic [7:0]          i_cf,
    output logic [7:0]               o_cf
);
    logic [32:0] wide;
    logic        msb, hc, ovf, zer, sa, sb;
    int          top, hpos;
    logic [4:0]  nib_a, nib_b;

    always_comb begin
        o_cf  = i_cf;
        top   = 31;
        hpos  = cpu_regs_pkg::HC_LONG;
        case (i_op.size)
            cpu_regs_pkg::SZ_BYTE: begin top = 7;  hpos = cpu_regs_pkg::HC_BYTE; end
            cpu_regs_pkg::SZ_WORD: begin top = 15; hpos = cpu_regs_pkg::HC_WORD; end
            default:               begin top = 31; hpos = cpu_regs_pkg::HC_LONG; end
        endcase
        if (i_op.kind == cpu_regs_pkg::AL_SUB) begin
            wide = {1'b0, i_op.a} - {1'b0, i_op.b} - {32'h0, i_op.cin};
        end else begin
            wide = {1'b0, i_op.a} + {1'b0, i_op.b} + {32'h0, i_op.cin};
        end
        // Bit hpos+1 of a^b^sum is the carry or borrow into it
        hc  = i_op.a[hpos+1] ^ i_op.b[hpos+1] ^ wide[hpos+1];
        msb = i_op.result[top];
        sa  = i_op.a[top];
        sb  = i_op.b[top];
        zer = 1'b1;
        for (int k = 0; k < 32; k++) begin
            if (k <= top && i_op.result[k]) zer = 1'b0;
        end
        if (i_op.kind == cpu_regs_pkg::AL_SUB) begin
            ovf = (sa != sb) && (msb != sa);
        end else begin
            ovf = (sa == sb) && (msb != sa);
        end
        nib_a = {1'b0, i_op.result[7:4]};
        nib_b = {1'b0, i_op.result[3:0]};
        case (i_op.kind)
            cpu_regs_pkg::AL_ADD, cpu_regs_pkg::AL_SUB: begin
                o_cf[cpu_regs_pkg::CF_H] = hc;                                  // [RL13]
                o_cf[cpu_regs_pkg::CF_N] = msb;                                 // [RL14]
                o_cf[cpu_regs_pkg::CF_Z] = zer;                                 // [RL15]
                o_cf[cpu_regs_pkg::CF_V] = ovf;                                 // [RL16]
                o_cf[cpu_regs_pkg::CF_C] = wide[top+1] ^ (top != 31 ?
                    i_op.a[top+1] ^ i_op.b[top+1] : 1'b0);                     // [RL17]
            end
            cpu_regs_pkg::AL_LOGIC: begin
                o_cf[cpu_regs_pkg::CF_N] = msb;                                 // [RL14]
                o_cf[cpu_regs_pkg::CF_Z] = zer;                                 // [RL15]
                o_cf[cpu_regs_pkg::CF_V] = 1'b0;                                // [RL16]
            end
            cpu_regs_pkg::AL_SHIFT: begin
                o_cf[cpu_regs_pkg::CF_N] = msb;
                o_cf[cpu_regs_pkg::CF_Z] = zer;
                o_cf[cpu_regs_pkg::CF_V] = 1'b0;
                o_cf[cpu_regs_pkg::CF_C] = i_op.shift_out;                      // [RL17]
            end
            cpu_regs_pkg::AL_BIT: begin
                // Carry is the one-bit accumulator; bit n of a byte
                o_cf[cpu_regs_pkg::CF_C] = i_op.bit_val;                        // [RL18] [RL19]
            end
            cpu_regs_pkg::AL_DAA, cpu_regs_pkg::AL_DAS: begin
                // Result is two packed BCD digits; carry keeps the decimal carry
                o_cf[cpu_regs_pkg::CF_N] = msb;                                 // [RL20]
                o_cf[cpu_regs_pkg::CF_Z] = zer;
                o_cf[cpu_regs_pkg::CF_C] = i_op.cin | (nib_a > 5'd9) | (nib_b > 5'd9);
            end
            default: o_cf = i_cf;
        endcase
    end
endmodule // flag_calc

// file: verilog/cpu_register_set_and_flags.sv
`timescale 1ns/1ps
// Operation
// [RL1] Eight 32-bit general registers, address or data
// [RL2] Data access at 32, 16 or 8 bits
// [RL3] Each splits into upper and lower halves
// [RL4] Lower half splits into high and low bytes
// [RL5] 24-bit instruction pointer, bit 0 fetched zero
// [RL6] Extend bit 7 enables trace after each instruction
// [RL7] Extend bits 2..0 mask level, 6..3 reserved
// [RL8] Extend change blocks all interrupts 3 states
// [RL9] Flag bit 7 masks all but non-maskable
// [RL10] Exception start sets flag interrupt mask
// [RL11] Bit 6 user bit, optional extra mask
// [RL12] Bit 4 plain software user bit
// [RL13] Half-carry from bit 3, 11, 27
// [RL14] Negative flag takes result sign bit
// [RL15] Zero flag set for zero result
// [RL16] Overflow flag set on arithmetic overflow
// [RL17] Carry holds carry, borrow, or shifted-out bit
// [RL18] Carry is bit-manipulation accumulator
// [RL19] Bit operations address bit 0..7 of byte
// [RL20] Decimal adjust treats byte as two BCD digits
// [RL21] Normal mode 64 kbytes, advanced 16 Mbytes
// [RL22] 64-bit multiply-accumulate register present
// [RL23] Normal mode drops upper 8 address bits
// [RL24] Partial view write keeps other bits
module cpu_register_set_and_flags #(
    parameter int NREGS = cpu_regs_pkg::NUM_REGS
) (
    input  wire logic                    I_CLK,
    input  wire logic                    I_ARST_N,
    input  cpu_regs_pkg::gpr_wr_t        i_GPR_WR,
    input  cpu_regs_pkg::gpr_rd_t        i_GPR_RD,
    output logic [31:0]                  o_GPR_RDATA,
    input  wire logic                    i_IP_LOAD,
    input  wire logic [23:0]             i_IP_DATA,
    input  wire logic                    i_IP_INC,
    output logic [23:0]                  o_IP,
    output logic [23:0]                  o_FETCH_ADDR,
    input  cpu_regs_pkg::ctrl_req_t      i_CTRL,
    output logic [7:0]                   o_EXTEND_CONTROL,
    output logic [7:0]                   o_CONDITION_FLAGS,
    input  cpu_regs_pkg::alu_flags_t     i_ALU,
    input  wire logic                    i_INSN_DONE,
    input  wire logic                    i_EXC_START,
    input  wire logic                    i_ADVANCED_MODE,
    input  wire logic                    i_UI_AS_MASK,
    input  wire logic [31:0]             i_EA,
    output logic [31:0]                  o_EA_OUT,
    input  wire logic                    i_IRQ_PEND,
    input  wire logic [2:0]              i_IRQ_LEVEL,
    input  wire logic                    i_IRQ_UI_CLASS,
    input  wire logic                    i_NMI_PEND,
    output logic                         o_IRQ_ACCEPT,
    output logic                         o_NMI_ACCEPT,
    output logic                         o_TRACE_REQ,
    input  wire logic                    i_MACC_WR,
    input  wire logic [63:0]             i_MACC_DATA,
    output logic [63:0]                  o_MACC
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [23:0] ip;
        logic [23:0] fetch;
        logic [7:0]  ext;
        logic [7:0]  cf;
        logic [63:0] macc;
        logic [1:0]  block_cnt;
        logic        irq_acc;
        logic        nmi_acc;
        logic        trace;
        logic [31:0] ea;
    } state_t;

    state_t      s_r;
    state_t      s_nxt;
    logic [7:0]  alu_cf;
    logic [7:0]  ctl_val;
    logic [7:0]  new_val;
    logic        int_block;
    logic        level_ok;

    ////////////////////////////////////////////////////////////////////////////
    gpr_bank #(
        .N (NREGS)
    ) u_gpr (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_wr     (i_GPR_WR),
        .i_rd     (i_GPR_RD),
        .o_rdata  (o_GPR_RDATA)
    );

    flag_calc u_flags (
        .i_op (i_ALU),
        .i_cf (s_r.cf),
        .o_cf (alu_cf)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;

        // Instruction pointer; load wins over increment
        if (i_IP_LOAD) begin
            s_nxt.ip = i_IP_DATA;                                              // [RL5]
        end else if (i_IP_INC) begin
            s_nxt.ip = s_r.ip + 24'h000002;
        end
        s_nxt.fetch = {s_nxt.ip[23:1], 1'b0};                                  // [RL5]
        if (!i_ADVANCED_MODE) begin
            s_nxt.fetch = {8'h00, s_nxt.fetch[15:0]};                          // [RL21]
        end

        // Effective address; normal mode keeps 16 bits only
        if (i_ADVANCED_MODE) begin
            s_nxt.ea = {8'h00, i_EA[23:0]};                                    // [RL21]
        end else begin
            s_nxt.ea = {16'h0000, i_EA[15:0]};                                 // [RL23]
        end

        // Arithmetic flags first; a control op on condition_flags in the same cycle overrides
        s_nxt.cf = alu_cf;                                                     // [RL13]

        ctl_val = i_CTRL.to_ext ? s_r.ext : s_r.cf;
        case (i_CTRL.op)
            cpu_regs_pkg::CO_LOAD: new_val = i_CTRL.data;
            cpu_regs_pkg::CO_AND:  new_val = ctl_val & i_CTRL.data;
            cpu_regs_pkg::CO_OR:   new_val = ctl_val | i_CTRL.data;
            cpu_regs_pkg::CO_XOR:  new_val = ctl_val ^ i_CTRL.data;
            default:               new_val = ctl_val;
        endcase
        if (i_CTRL.op != cpu_regs_pkg::CO_NONE) begin
            if (i_CTRL.to_ext) begin
                // Reserved bits 6..3 always read zero
                s_nxt.ext = new_val & cpu_regs_pkg::EXT_WR_MASK;               // [RL7]
            end else begin
                s_nxt.cf = new_val;                                            // [RL11] [RL12]
            end
        end

        // Exception start forces the mask after everything else
        if (i_EXC_START) begin
            s_nxt.cf[cpu_regs_pkg::CF_I] = 1'b1;                               // [RL10]
        end

        // Store is not a control op here, so it never starts the window
        if (i_CTRL.op != cpu_regs_pkg::CO_NONE && i_CTRL.to_ext) begin
            s_nxt.block_cnt = cpu_regs_pkg::EXT_BLOCK_LOAD;                    // [RL8]
        end else if (s_r.block_cnt != 2'b00) begin
            s_nxt.block_cnt = s_r.block_cnt - 2'b01;                           // [RL8]
        end

        // Interrupt acceptance, one cycle late from registered state
        int_block = (s_r.block_cnt != 2'b00)
            || (i_CTRL.op != cpu_regs_pkg::CO_NONE && i_CTRL.to_ext);            // [RL8]
        level_ok  = (i_IRQ_LEVEL > s_r.ext[cpu_regs_pkg::EXT_LVL_HI:cpu_regs_pkg::EXT_LVL_LO]); // [RL7]
        s_nxt.nmi_acc = i_NMI_PEND && !int_block;                              // [RL8] [RL9]
        s_nxt.irq_acc = i_IRQ_PEND && !int_block && !i_NMI_PEND
            && !s_r.cf[cpu_regs_pkg::CF_I] && level_ok                         // [RL9]
            && !(i_UI_AS_MASK && i_IRQ_UI_CLASS && s_r.cf[cpu_regs_pkg::CF_UI]); // [RL11]

        // Trace request after each finished instruction
        s_nxt.trace = i_INSN_DONE && s_r.ext[cpu_regs_pkg::EXT_TRACE_BIT];     // [RL6]

        if (i_MACC_WR) begin
            s_nxt.macc = i_MACC_DATA;                                          // [RL22]
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s_r.ip        <= cpu_regs_pkg::IP_RESET;
            s_r.fetch     <= cpu_regs_pkg::IP_RESET;
            s_r.ext       <= cpu_regs_pkg::EXT_RESET;
            s_r.cf        <= cpu_regs_pkg::CF_RESET;
            s_r.macc      <= cpu_regs_pkg::MACC_RESET;
            s_r.block_cnt <= 2'b00;
            s_r.irq_acc   <= 1'b0;
            s_r.nmi_acc   <= 1'b0;
            s_r.trace     <= 1'b0;
            s_r.ea        <= 32'h00000000;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign o_IP              = s_r.ip;
    assign o_FETCH_ADDR      = s_r.fetch;
    assign o_EXTEND_CONTROL  = s_r.ext;
    assign o_CONDITION_FLAGS = s_r.cf;
    assign o_MACC            = s_r.macc;
    assign o_EA_OUT          = s_r.ea;
    assign o_IRQ_ACCEPT      = s_r.irq_acc;
    assign o_NMI_ACCEPT      = s_r.nmi_acc;
    assign o_TRACE_REQ       = s_r.trace;
endmodule // cpu_register_set_and_flags

// file: dv/cpu_regs_checker.sv
`timescale 1ns/1ps
module cpu_regs_checker #(
    parameter int NREGS = 8
) (
    input  wire logic              I_CLK,
    input  wire logic              I_ARST_N,
    input  cpu_regs_pkg::ctrl_req_t i_CTRL,
    input  wire logic [7:0]        o_EXTEND_CONTROL,
    input  wire logic [7:0]        o_CONDITION_FLAGS,
    input  wire logic              i_INSN_DONE,
    input  wire logic              i_EXC_START,
    input  wire logic              i_ADVANCED_MODE,
    input  wire logic [31:0]       i_EA,
    input  wire logic [31:0]       o_EA_OUT,
    input  wire logic [2:0]        i_IRQ_LEVEL,
    input  wire logic              i_NMI_PEND,
    input  wire logic              i_IP_LOAD,
    input  wire logic              i_IP_INC,
    input  wire logic [23:0]       o_IP,
    input  wire logic [23:0]       o_FETCH_ADDR,
    input  wire logic              o_IRQ_ACCEPT,
    input  wire logic              o_NMI_ACCEPT,
    input  wire logic              o_TRACE_REQ
);
    logic       ext_op;
    logic [1:0] blk_r;
    // Shadow of the refusal window: the request edge plus two more edges
    assign ext_op = (i_CTRL.op != cpu_regs_pkg::CO_NONE) && i_CTRL.to_ext;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            blk_r <= 2'h0;
        end else if (ext_op) begin
            blk_r <= 2'h2;
        end else if (blk_r != 2'h0) begin
            blk_r <= blk_r - 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    fetch_even_a: assert property (o_FETCH_ADDR[0] == 1'b0)
        else $error("Fetch address odd");
    ip_step_a: assert property (i_IP_INC && !i_IP_LOAD |=> o_IP == $past(o_IP) + 24'h2)
        else $error("Pointer step wrong");
    trace_req_a: assert property (i_INSN_DONE && o_EXTEND_CONTROL[7] |=> o_TRACE_REQ)
        else $error("Trace request missing");
    trace_off_a: assert property (!o_EXTEND_CONTROL[7] |=> !o_TRACE_REQ)
        else $error("Trace request while off");
    ext_resv_a: assert property (o_EXTEND_CONTROL[6:3] == 4'h0)
        else $error("Reserved extend bits set");
    ext_load_a: assert property (i_CTRL.op == cpu_regs_pkg::CO_LOAD && i_CTRL.to_ext
        |=> o_EXTEND_CONTROL == ($past(i_CTRL.data) & cpu_regs_pkg::EXT_WR_MASK))
        else $error("Extend load wrong");
    ext_block_a: assert property (ext_op |=> (!o_IRQ_ACCEPT && !o_NMI_ACCEPT) [*3])
        else $error("Accept in refusal window");
    irq_mask_a: assert property (o_CONDITION_FLAGS[7]
        || i_IRQ_LEVEL <= o_EXTEND_CONTROL[2:0] |=> !o_IRQ_ACCEPT)
        else $error("Masked interrupt taken");
    nmi_take_a: assert property (i_NMI_PEND && !ext_op && blk_r == 2'h0 |=> o_NMI_ACCEPT)
        else $error("NMI refused");
    exc_mask_a: assert property (i_EXC_START |=> o_CONDITION_FLAGS[7])
        else $error("Exception left mask clear");
    cf_load_a: assert property (i_CTRL.op == cpu_regs_pkg::CO_LOAD && !i_CTRL.to_ext
        |=> o_CONDITION_FLAGS[6:0] == $past(i_CTRL.data[6:0]))
        else $error("Flag load wrong");
    ea_norm_a: assert property (!i_ADVANCED_MODE |=> o_EA_OUT == {16'h0, $past(i_EA[15:0])})
        else $error("Normal address not cut");
    cover property (o_TRACE_REQ);
    cover property (o_NMI_ACCEPT);
    cover property (o_IRQ_ACCEPT);
endmodule // cpu_regs_checker

bind cpu_register_set_and_flags cpu_regs_checker #(.NREGS(NREGS)) chk_u (
    .I_CLK, .I_ARST_N, .i_CTRL, .o_EXTEND_CONTROL, .o_CONDITION_FLAGS, .i_INSN_DONE,
    .i_EXC_START, .i_ADVANCED_MODE, .i_EA, .o_EA_OUT, .i_IP_INC, .i_IRQ_LEVEL, .i_NMI_PEND,
    .i_IP_LOAD, .o_IP, .o_FETCH_ADDR, .o_IRQ_ACCEPT, .o_NMI_ACCEPT, .o_TRACE_REQ
);

// file: dv/exec_model.sv
`timescale 1ns/1ps
module exec_model (
    input  wire logic                i_clk,
    input  wire logic [31:0]         i_rdata,
    output cpu_regs_pkg::gpr_wr_t    o_wr,
    output cpu_regs_pkg::gpr_rd_t    o_rd,
    output cpu_regs_pkg::ctrl_req_t  o_ctrl,
    output cpu_regs_pkg::alu_flags_t o_alu,
    output logic [7:0]               o_pls,
    output logic [7:0]               o_lvl,
    output logic [31:0]              o_ea,
    output logic [23:0]              o_ip,
    output logic [63:0]              o_macc
);
    initial begin
        o_wr = '0;
        o_rd = '0;
        o_ctrl = '0;
        o_alu = '0;
        o_pls = 8'h00;
        o_lvl = 8'h00;
        o_ea = 32'h0;
        o_ip = 24'h0;
        o_macc = 64'h0;
    end
    // One-shots drop on their edge, so none is taken twice
    task automatic go();
        @(posedge i_clk);
        o_wr.en <= 1'b0;
        o_ctrl.op <= cpu_regs_pkg::CO_NONE;
        o_alu.kind <= cpu_regs_pkg::AL_NONE;
        o_pls <= 8'h00;
        #1;
    endtask
    task automatic gwr(input logic [2:0] i, input cpu_regs_pkg::reg_view_t v, input logic h,
                       input logic [31:0] d);
        o_wr = '{1'b1, i, v, h, d};
        go();
    endtask
    task automatic grd(input logic [2:0] i, input cpu_regs_pkg::reg_view_t v, input logic h,
                       output logic [31:0] d);
        o_rd = '{i, v, h};
        go();
        d = i_rdata;
    endtask
    task automatic ctrl(input cpu_regs_pkg::ctrl_op_t op, input logic x, input logic [7:0] d);
        o_ctrl = '{op, x, d};
        go();
    endtask
    task automatic alu(input cpu_regs_pkg::alu_kind_t k, input cpu_regs_pkg::op_size_t s,
                       input logic [31:0] a, b, r, input logic so, bv);
        o_alu = '{k, s, a, b, 1'b0, r, so, bv, 3'h0};
        go();
    endtask
    task automatic pulse(input logic [7:0] p, input logic [23:0] ip, input logic [63:0] m);
        o_pls = p;
        o_ip = ip;
        o_macc = m;
        go();
    endtask
    task automatic lvl(input logic [7:0] v, input logic [31:0] ea);
        o_lvl = v;
        o_ea = ea;
        go();
    endtask
endmodule // exec_model

// file: dv/test_cpu_register_set_and_flags.sv
`timescale 1ns/1ps
module test_cpu_register_set_and_flags;
    logic                     clk = 1'b0;
    logic                     arst_n;
    cpu_regs_pkg::gpr_wr_t    wr;
    cpu_regs_pkg::gpr_rd_t    rd;
    cpu_regs_pkg::ctrl_req_t  ctrl;
    cpu_regs_pkg::alu_flags_t alu;
    logic [7:0]               pls, lv, ext, cf;
    logic [31:0]              ea, eao, rdata;
    logic [23:0]              ipd, ip, fa;
    logic [63:0]              md, mac;
    logic                     irq, nmi, trc;
    int                       num_errors = 0;
    int                       num_checks = 0;
    int                       cycles = 0;
    localparam logic [7:0]    DV [4] = '{8'hff, 8'h80, 8'h03, 8'h81};
    localparam logic [7:0]    EE [4] = '{8'h87, 8'h80, 8'h83, 8'h02};
    localparam logic [7:0]    EC [4] = '{8'hff, 8'h80, 8'h83, 8'h02};
    always #2.5 clk = ~clk;
    exec_model p_u (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_ctrl(ctrl),
        .o_alu(alu), .o_pls(pls), .o_lvl(lv), .o_ea(ea), .o_ip(ipd), .o_macc(md));
    cpu_register_set_and_flags dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .i_GPR_WR(wr),
        .i_GPR_RD(rd), .o_GPR_RDATA(rdata), .i_IP_LOAD(pls[0]), .i_IP_DATA(ipd),
        .i_IP_INC(pls[1]), .o_IP(ip), .o_FETCH_ADDR(fa), .i_CTRL(ctrl),
        .o_EXTEND_CONTROL(ext), .o_CONDITION_FLAGS(cf), .i_ALU(alu), .i_INSN_DONE(pls[2]),
        .i_EXC_START(pls[3]), .i_ADVANCED_MODE(lv[0]), .i_UI_AS_MASK(lv[1]), .i_EA(ea),
        .o_EA_OUT(eao), .i_IRQ_PEND(lv[2]), .i_IRQ_LEVEL(lv[7:5]), .i_IRQ_UI_CLASS(lv[3]),
        .i_NMI_PEND(lv[4]), .o_IRQ_ACCEPT(irq), .o_NMI_ACCEPT(nmi), .o_TRACE_REQ(trc),
        .i_MACC_WR(pls[4]), .i_MACC_DATA(md), .o_MACC(mac));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] s, e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic rchk(input logic [2:0] i, logic [31:0] e,
                        cpu_regs_pkg::reg_view_t v = cpu_regs_pkg::V_LONG, logic h = 1'b0);
        logic [31:0] d;
        p_u.grd(i, v, h, d);
        chk(d, e);
    endtask
    task automatic t_reset();
        chk({ext, cf, ip}, 40'h0780000000);
        chk(mac, 64'h0);
        rchk(3'h5, 32'h0);
    endtask
    task automatic t_gpr();
        for (int i = 0; i < 8; i++) p_u.gwr(3'(i), cpu_regs_pkg::V_LONG, 1'b0, 32'(i + 1) * 32'h01010101);
        for (int i = 0; i < 8; i++) rchk(3'(i), 32'(i + 1) * 32'h01010101);
        p_u.gwr(3'h3, cpu_regs_pkg::V_BYTE, 1'b1, 32'haa);
        p_u.gwr(3'h3, cpu_regs_pkg::V_BYTE, 1'b0, 32'h55);
        p_u.gwr(3'h3, cpu_regs_pkg::V_UPPER, 1'b0, 32'h1234);
        p_u.gwr(3'h2, cpu_regs_pkg::V_LOWER, 1'b0, 32'hbeef);
        rchk(3'h3, 32'h1234aa55);
        rchk(3'h3, 32'h1234, cpu_regs_pkg::V_UPPER);
        rchk(3'h3, 32'haa55, cpu_regs_pkg::V_LOWER);
        rchk(3'h3, 32'haa, cpu_regs_pkg::V_BYTE, 1'b1);
        rchk(3'h3, 32'h55, cpu_regs_pkg::V_BYTE);
        rchk(3'h2, 32'h0303beef);
        rchk(3'h4, 32'h05050505);
    endtask
    task automatic t_ctrl();
        for (int i = 0; i < 4; i++) begin
            p_u.ctrl(cpu_regs_pkg::ctrl_op_t'(3'(i + 1)), 1'b1, DV[i]);
            chk(ext, EE[i]);
            p_u.ctrl(cpu_regs_pkg::ctrl_op_t'(3'(i + 1)), 1'b0, DV[i]);
            chk(cf, EC[i]);
        end
    endtask
    task automatic t_ipmac();
        p_u.lvl(8'h01, 32'hdeadbeef);
        chk(eao, 32'h00adbeef);
        p_u.pulse(8'h01, 24'h123457, 64'h0);
        chk({ip, fa}, 48'h123457123456);
        p_u.pulse(8'h02, 24'h0, 64'h0);
        chk(ip, 24'h123459);
        p_u.lvl(8'h00, 32'hdeadbeef);
        chk(eao, 32'h0000beef);
        chk(fa, 24'h003458);
        p_u.pulse(8'h10, 24'h0, 64'h0123456789abcdef);
        chk(mac, 64'h0123456789abcdef);
    endtask
    task automatic af(cpu_regs_pkg::alu_kind_t k, cpu_regs_pkg::op_size_t s,
                      logic [31:0] a, b, r, logic [4:0] e);
        p_u.alu(k, s, a, b, r, 1'b0, 1'b0);
        chk({cf[5], cf[3:0]}, e);
    endtask
    task automatic t_alu();
        af(cpu_regs_pkg::AL_ADD, cpu_regs_pkg::SZ_BYTE, 32'h0f, 32'h01, 32'h10, 5'h10);
        af(cpu_regs_pkg::AL_ADD, cpu_regs_pkg::SZ_BYTE, 32'h80, 32'h80, 32'h0, 5'h07);
        af(cpu_regs_pkg::AL_SUB, cpu_regs_pkg::SZ_WORD, 32'h0, 32'h1, 32'hffff, 5'h19);
        af(cpu_regs_pkg::AL_ADD, cpu_regs_pkg::SZ_LONG, 32'h7fffffff, 32'h1, 32'h80000000, 5'h1a);
        p_u.alu(cpu_regs_pkg::AL_SHIFT, cpu_regs_pkg::SZ_BYTE, 32'h81, 32'h0, 32'h02, 1'b1, 1'b0);
        chk(cf[0], 1'b1);
        p_u.alu(cpu_regs_pkg::AL_BIT, cpu_regs_pkg::SZ_BYTE, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0);
        chk(cf[0], 1'b0);
    endtask
    task automatic t_irq();
        p_u.ctrl(cpu_regs_pkg::CO_LOAD, 1'b1, 8'h02);
        p_u.ctrl(cpu_regs_pkg::CO_LOAD, 1'b0, 8'h00);
        p_u.lvl(8'h64, 32'h0);
        repeat (3) step();
        chk(irq, 1'b1);
        p_u.lvl(8'h44, 32'h0);
        chk(irq, 1'b0);
        p_u.ctrl(cpu_regs_pkg::CO_OR, 1'b0, 8'h80);
        p_u.lvl(8'h64, 32'h0);
        chk(irq, 1'b0);
        p_u.lvl(8'h74, 32'h0);
        chk(nmi, 1'b1);
        p_u.ctrl(cpu_regs_pkg::CO_XOR, 1'b1, 8'h00);
        for (int i = 0; i < 3; i++) begin
            chk(nmi, 1'b0);
            step();
        end
        chk(nmi, 1'b1);
        p_u.ctrl(cpu_regs_pkg::CO_LOAD, 1'b1, 8'h80);
        p_u.pulse(8'h04, 24'h0, 64'h0);
        chk(trc, 1'b1);
        p_u.ctrl(cpu_regs_pkg::CO_AND, 1'b0, 8'h00);
        p_u.pulse(8'h08, 24'h0, 64'h0);
        chk(cf[7], 1'b1);
    endtask
    task automatic complete_run();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        arst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_gpr();
        t_ctrl();
        t_ipmac();
        t_alu();
        t_irq();
        complete_run();
    end
endmodule // test_cpu_register_set_and_flags
